// *** rtl/tis_tap_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Exit2-IR with TMS high goes Update-IR
// - Exit2-IR with TMS low returns Shift-IR
// - Exit2-IR keeps data register and instruction
// - Update-IR latches instruction on falling TCK
// - latched instruction selects the data register
// - Update-IR leaves data registers unchanged
// - Pause-IR waits for TMS high, then Exit2-IR
// - Capture-IR loads fixed pattern 100
// - Shift-IR shifts TDI toward TDO each rise
module tis_tap_ctrl #(
    parameter int IR_W = tis_pkg::IR_W_DEF,
    parameter int DR_W = tis_pkg::DR_W_DEF
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              ce,
    input  wire tis_pkg::tis_pins_t pins,
    output logic                   tdo,
    output logic                   tdoEn,
    output logic [IR_W-1:0]        instr,
    output logic [DR_W-1:0]        drOut,
    output tis_pkg::tis_state_t    tapState
);

    // the logic serves the three-bit pattern and one data width only
    if (IR_W != 3 || DR_W != 8) begin : g_badWidth
        $error("tis_tap_ctrl: IR_W must be 3 and DR_W 8");
    end

    tis_pkg::tis_pins_t  pinsS;     // synced pins
    logic                tckRise;   // rising test clock, one cycle
    logic                tckFall;   // falling test clock, one cycle
    tis_pkg::tis_state_t state_r;   // controller state
    tis_pkg::tis_state_t state_nxt; // next state on a rise
    logic [IR_W-1:0]     irSh_r;    // instruction shift path
    logic [IR_W-1:0]     irCur_r;   // current instruction latch
    logic                byp_r;     // bypass stage
    logic [DR_W-1:0]     drSh_r;    // user data shift path
    logic [DR_W-1:0]     drOut_r;   // user data parallel latch
    logic                tdo_r;     // serial output
    logic                tdoEn_r;   // serial output enable
    logic                bypSel;    // bypass chosen by instruction

    // pin synchroniser and edge finder
    tis_pin_sync u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .ce       (ce),
        .pinsIn   (pins),
        .pinsSync (pinsS),
        .tckRise  (tckRise),
        .tckFall  (tckFall)
    );

    // next state from state and mode select
    function automatic tis_pkg::tis_state_t nextState(tis_pkg::tis_state_t s, logic m);
        case (s)
            tis_pkg::TEST_LOGIC_RESET: nextState = m ? tis_pkg::TEST_LOGIC_RESET : tis_pkg::RUN_TEST_IDLE;
            tis_pkg::RUN_TEST_IDLE:    nextState = m ? tis_pkg::SELECT_DR_SCAN : tis_pkg::RUN_TEST_IDLE;
            tis_pkg::SELECT_DR_SCAN:   nextState = m ? tis_pkg::SELECT_IR_SCAN : tis_pkg::CAPTURE_DR;
            tis_pkg::CAPTURE_DR:       nextState = m ? tis_pkg::EXIT1_DR : tis_pkg::SHIFT_DR;
            tis_pkg::SHIFT_DR:         nextState = m ? tis_pkg::EXIT1_DR : tis_pkg::SHIFT_DR;
            tis_pkg::EXIT1_DR:         nextState = m ? tis_pkg::UPDATE_DR : tis_pkg::PAUSE_DR;
            tis_pkg::PAUSE_DR:         nextState = m ? tis_pkg::EXIT2_DR : tis_pkg::PAUSE_DR;
            tis_pkg::EXIT2_DR:         nextState = m ? tis_pkg::UPDATE_DR : tis_pkg::SHIFT_DR;
            tis_pkg::UPDATE_DR:        nextState = m ? tis_pkg::SELECT_DR_SCAN : tis_pkg::RUN_TEST_IDLE;
            tis_pkg::SELECT_IR_SCAN:   nextState = m ? tis_pkg::TEST_LOGIC_RESET : tis_pkg::CAPTURE_IR;
            tis_pkg::CAPTURE_IR:       nextState = m ? tis_pkg::EXIT1_IR : tis_pkg::SHIFT_IR;
            tis_pkg::SHIFT_IR:         nextState = m ? tis_pkg::EXIT1_IR : tis_pkg::SHIFT_IR;
            tis_pkg::EXIT1_IR:         nextState = m ? tis_pkg::UPDATE_IR : tis_pkg::PAUSE_IR;
            tis_pkg::PAUSE_IR:         nextState = m ? tis_pkg::EXIT2_IR : tis_pkg::PAUSE_IR;
            tis_pkg::EXIT2_IR:         nextState = m ? tis_pkg::UPDATE_IR : tis_pkg::SHIFT_IR;
            tis_pkg::UPDATE_IR:        nextState = m ? tis_pkg::SELECT_DR_SCAN : tis_pkg::RUN_TEST_IDLE;
            default:                   nextState = tis_pkg::TEST_LOGIC_RESET;
        endcase
    endfunction

    assign state_nxt = nextState(state_r, pinsS.tms);

    assign bypSel = (irCur_r == tis_pkg::IR_RESET);

    // controller state advances on each test clock rise
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r <= tis_pkg::TEST_LOGIC_RESET;
        end else if (tckRise) begin
            state_r <= state_nxt;
        end
    end

    // instruction shift path on test clock rise
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irSh_r <= tis_pkg::IR_CAPTURE;
        end else if (tckRise) begin
            case (state_r)
                tis_pkg::CAPTURE_IR: irSh_r <= tis_pkg::IR_CAPTURE;
                tis_pkg::SHIFT_IR:   irSh_r <= {pinsS.tdi, irSh_r[IR_W-1:1]};
                default:             irSh_r <= irSh_r;
            endcase
        end
    end

    // current instruction changes only on the fall in Update-IR or Test-Logic-Reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irCur_r <= tis_pkg::IR_RESET;
        end else if (tckFall && state_r == tis_pkg::TEST_LOGIC_RESET) begin
            irCur_r <= tis_pkg::IR_RESET;
        end else if (tckFall && state_r == tis_pkg::UPDATE_IR) begin
            irCur_r <= irSh_r;
        end
    end

    // data paths move only in the data column; hold elsewhere
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            byp_r  <= 1'h0;
            drSh_r <= tis_pkg::DR_RESET;
        end else if (tckRise) begin
            if (state_r == tis_pkg::CAPTURE_DR) begin
                byp_r <= 1'h0;
                if (!bypSel) begin
                    drSh_r <= drOut_r;
                end
            end else if (state_r == tis_pkg::SHIFT_DR) begin
                if (bypSel) begin
                    byp_r <= pinsS.tdi;
                end else begin
                    drSh_r <= {pinsS.tdi, drSh_r[DR_W-1:1]};
                end
            end
        end
    end

    // user data latch updates on the fall in its own update state
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            drOut_r <= tis_pkg::DR_RESET;
        end else if (tckFall && state_r == tis_pkg::UPDATE_DR && !bypSel) begin
            drOut_r <= drSh_r;
        end
    end

    // serial output changes on the fall while shifting
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tdo_r   <= 1'h0;
            tdoEn_r <= 1'h0;
        end else if (tckFall) begin
            if (state_r == tis_pkg::SHIFT_IR) begin
                tdo_r   <= irSh_r[0];
                tdoEn_r <= 1'h1;
            end else if (state_r == tis_pkg::SHIFT_DR) begin
                tdo_r   <= bypSel ? byp_r : drSh_r[0];
                tdoEn_r <= 1'h1;
            end else begin
                tdoEn_r <= 1'h0;
            end
        end
    end

    assign tdo      = tdo_r;
    assign tdoEn    = tdoEn_r;
    assign instr    = irCur_r;
    assign drOut    = drOut_r;
    assign tapState = state_r;

    // checks
    sequence riseIn(tis_pkg::tis_state_t s);
        tckRise && state_r == s;
    endsequence

    sequence fallIn(tis_pkg::tis_state_t s);
        tckFall && state_r == s;
    endsequence

    property exitStep(tis_pkg::tis_state_t s, logic m, tis_pkg::tis_state_t d);
        @(posedge clk_sys) disable iff (reset)
        (riseIn(s) and pinsS.tms == m) |=> state_r == d;
    endproperty

    exit2_update_a: assert property (exitStep(tis_pkg::EXIT2_IR, 1'h1, tis_pkg::UPDATE_IR))
        else $error("exit2 with tms high did not reach update");
    exit2_shift_a: assert property (exitStep(tis_pkg::EXIT2_IR, 1'h0, tis_pkg::SHIFT_IR))
        else $error("exit2 with tms low did not return to shift");
    exit2_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        state_r == tis_pkg::EXIT2_IR |=> $stable(irCur_r) && $stable(drSh_r) && $stable(byp_r))
        else $error("exit2 changed instruction or data register");
    update_latch_a: assert property (@(posedge clk_sys) disable iff (reset)
        fallIn(tis_pkg::UPDATE_IR) |=> irCur_r == $past(irSh_r))
        else $error("update did not latch the shifted instruction");
    update_only_a: assert property (@(posedge clk_sys) disable iff (reset)
        !(tckFall && (state_r == tis_pkg::UPDATE_IR || state_r == tis_pkg::TEST_LOGIC_RESET))
        |=> $stable(irCur_r))
        else $error("instruction changed outside update");
    select_path_a: assert property (@(posedge clk_sys) disable iff (reset)
        (riseIn(tis_pkg::SHIFT_DR) and !bypSel) |=> byp_r == $past(byp_r) && drSh_r[DR_W-1] == $past(pinsS.tdi))
        else $error("current instruction did not steer the data path");
    update_dr_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        state_r == tis_pkg::UPDATE_IR |=> $stable(drSh_r) && $stable(drOut_r))
        else $error("update changed a data register");
    pause_stay_a: assert property (exitStep(tis_pkg::PAUSE_IR, 1'h0, tis_pkg::PAUSE_IR))
        else $error("pause left with tms low");
    pause_exit_a: assert property (exitStep(tis_pkg::PAUSE_IR, 1'h1, tis_pkg::EXIT2_IR))
        else $error("pause did not go to exit2");
    capture_ir_a: assert property (@(posedge clk_sys) disable iff (reset)
        riseIn(tis_pkg::CAPTURE_IR) |=> irSh_r == tis_pkg::IR_CAPTURE)
        else $error("capture did not load the fixed pattern");
    shift_ir_a: assert property (@(posedge clk_sys) disable iff (reset)
        riseIn(tis_pkg::SHIFT_IR) |=> irSh_r == {$past(pinsS.tdi), $past(irSh_r[IR_W-1:1])})
        else $error("instruction path did not shift one stage");
    update_next_a: assert property (@(posedge clk_sys) disable iff (reset)
        (riseIn(tis_pkg::UPDATE_IR) and !pinsS.tms) |=> state_r == tis_pkg::RUN_TEST_IDLE)
        else $error("update with tms low did not reach idle");
    update_select_a: assert property (exitStep(tis_pkg::UPDATE_IR, 1'h1, tis_pkg::SELECT_DR_SCAN))
        else $error("update with tms high did not reach select dr");

endmodule

`default_nettype wire

// *** rtl/tis_pkg.sv ***
package tis_pkg;

    // instruction register geometry
    localparam int IR_W_DEF        = 3;
    // fixed pattern loaded while capturing the instruction path
    localparam logic [2:0] IR_CAPTURE = 3'h4;
    // instruction after reset: all ones selects the one-bit bypass path
    localparam logic [2:0] IR_RESET   = 3'h7;
    // width of the user data register behind the port
    localparam int DR_W_DEF        = 8;
    // reset value of the user data register
    localparam logic [7:0] DR_RESET   = 8'h00;
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES     = 2;

    // port controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR_SCAN,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR_SCAN,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tis_state_t;

    // test pins from the external tester
    typedef struct packed {
        logic tck;  // test clock
        logic tms;  // mode select
        logic tdi;  // serial data in
    } tis_pins_t;

endpackage

// *** rtl/tis_pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// brings the tester pins into clk_sys and finds test clock edges
module tis_pin_sync (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              ce,
    input  wire tis_pkg::tis_pins_t pinsIn,
    output tis_pkg::tis_pins_t     pinsSync,
    output logic                   tckRise,
    output logic                   tckFall
);

    tis_pkg::tis_pins_t meta_r;   // first stage, read only by second
    tis_pkg::tis_pins_t sync_r;   // second stage, safe to use
    logic               tckOld_r; // previous synced clock level

    // two flip-flop synchroniser
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_r <= '0;
            sync_r <= '0;
        end else if (ce) begin
            meta_r <= pinsIn;
            sync_r <= meta_r;
        end
    end

    // delayed clock level for edge finding
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tckOld_r <= 1'h0;
        end else if (ce) begin
            tckOld_r <= sync_r.tck;
        end
    end

    assign pinsSync = sync_r;
    // edges are qualified by ce so frozen cycles see none
    assign tckRise  = ce & sync_r.tck & ~tckOld_r;
    assign tckFall  = ce & ~sync_r.tck & tckOld_r;

endmodule

`default_nettype wire

// *** bench/tis_tester.sv ***
`timescale 1ns/10ps
`default_nettype none

// tester model: drives the test pins, test clock parked low between steps
module tis_tester (
    input  wire logic          clk_sys,
    output tis_pkg::tis_pins_t pins,
    output logic               sampleNow
);
    // pins idle, clock low
    initial begin
        pins = '0;
        sampleNow = 1'h0;
    end

    // one 200 ns test clock period: mode and data change with the fall,
    // the rise follows 100 ns later; called at a falling clk_sys edge
    task automatic step(input logic tms, input logic tdi);
        pins.tms = tms;
        pins.tdi = tdi;
        repeat (4) @(negedge clk_sys);
        pins.tck = 1'h1;
        repeat (2) @(negedge clk_sys);
        // data released after the rise: inverted so a late sample shows
        pins.tdi = ~tdi;
        repeat (2) @(negedge clk_sys);
        pins.tck = 1'h0;
        // outputs settle 3 clk_sys after the fall; sample in the low phase
        fork
            begin
                repeat (3) @(negedge clk_sys);
                sampleNow = 1'h1;
                @(negedge clk_sys);
                sampleNow = 1'h0;
            end
        join_none
    endtask
endmodule

`default_nettype wire

// *** bench/tap_ir_exit2_update_states_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module tap_ir_exit2_update_states_test;
    logic                clk_sys;   // system clock
    logic                reset;     // async reset
    logic                ce;        // clock enable
    tis_pkg::tis_pins_t  pins;      // tester pins
    logic                sampleNow; // outputs settled
    logic                tdo;
    logic                tdoEn;
    logic [2:0]          instr;
    logic [7:0]          drOut;
    tis_pkg::tis_state_t tapState;
    tis_pkg::tis_state_t cur;       // expected state
    logic [16:0]         expQ[$];   // {tdoEn, tdo, instr, drOut, state}
    logic [16:0]         mskQ[$];   // which bits count
    logic [16:0]         act;
    logic [16:0]         e;
    logic [16:0]         m;
    logic [2:0]          irSh;      // model of instruction path
    logic [2:0]          expInstr;
    logic [2:0]          v;
    logic [7:0]          drSh;      // model of data path
    logic [7:0]          expDr;
    int                  err_count = 0;
    int                  n_checks = 0;
    int                  cycles = 0;
    int                  seed = 32'h872cf6f9;

    tis_tap_ctrl i_tis_tap_ctrl (.clk_sys(clk_sys), .reset(reset), .ce(ce), .pins(pins), .tdo(tdo),
        .tdoEn(tdoEn), .instr(instr), .drOut(drOut), .tapState(tapState));
    tis_tester tester (.clk_sys(clk_sys), .pins(pins), .sampleNow(sampleNow));

    // 40 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] rnd8();
        int r;
        r = $random(seed);
        return r[7:0];
    endfunction

    function automatic logic rb();
        logic [7:0] t;
        t = rnd8();
        return t[0];
    endfunction

    task automatic tally_and_finish();
        if (err_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [16:0] a, input logic [16:0] b);
        n_checks++;
        if (a !== b) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, a, b);
        end
    endtask

    // one test clock step: model updates, note expectation, drive pins
    task automatic stp(input logic tms, input logic tdi, input tis_pkg::tis_state_t nxt);
        logic byp;
        logic sh;
        byp = (expInstr === tis_pkg::IR_RESET);
        if (cur == tis_pkg::CAPTURE_IR) irSh = tis_pkg::IR_CAPTURE;
        if (cur == tis_pkg::SHIFT_IR) irSh = {tdi, irSh[2:1]};
        if (cur == tis_pkg::CAPTURE_DR) drSh = byp ? 8'h00 : expDr;
        if (cur == tis_pkg::SHIFT_DR) drSh = byp ? {7'h00, tdi} : {tdi, drSh[7:1]};
        cur = nxt;
        if (cur == tis_pkg::UPDATE_IR) expInstr = irSh;
        if (cur == tis_pkg::TEST_LOGIC_RESET) expInstr = tis_pkg::IR_RESET;
        if (cur == tis_pkg::UPDATE_DR && !byp) expDr = drSh;
        sh = (cur == tis_pkg::SHIFT_IR) || (cur == tis_pkg::SHIFT_DR);
        expQ.push_back({sh, (cur == tis_pkg::SHIFT_IR) ? irSh[0] : drSh[0], expInstr, expDr, cur});
        mskQ.push_back({1'b1, sh, 15'h7fff});
        tester.step(tms, tdi);
    endtask

    // shift n bits, leaving on the last one
    task automatic shiftBits(input int n, input logic [7:0] d, input tis_pkg::tis_state_t s,
                             input tis_pkg::tis_state_t ex);
        for (int i = 0; i < n; i++) begin
            if (i == n - 1) stp(1'h1, d[i], ex);
            else stp(1'h0, d[i], s);
        end
    endtask

    // compare each settled snapshot with the oldest note
    always @(posedge sampleNow) begin
        act = {tdoEn, tdo, instr, drOut, tapState};
        e = expQ.pop_front();
        m = mskQ.pop_front();
        check(act & m, e & m);
    end

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        reset = 1'h1;
        ce = 1'h1;
        cur = tis_pkg::TEST_LOGIC_RESET;
        expInstr = tis_pkg::IR_RESET;
        expDr = tis_pkg::DR_RESET;
        irSh = tis_pkg::IR_CAPTURE;
        drSh = 8'h00;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'h0;
        stp(1'h1, rb(), tis_pkg::TEST_LOGIC_RESET);
        stp(1'h0, rb(), tis_pkg::RUN_TEST_IDLE);
        // round 0 loads a user instruction, round 1 the bypass one
        for (int r = 0; r < 2; r++) begin
            v = (r == 0) ? {1'h0, rb(), rb()} : tis_pkg::IR_RESET;
            stp(1'h1, rb(), tis_pkg::SELECT_DR_SCAN);
            stp(1'h1, rb(), tis_pkg::SELECT_IR_SCAN);
            stp(1'h0, rb(), tis_pkg::CAPTURE_IR);
            stp(1'h0, rb(), tis_pkg::SHIFT_IR);
            shiftBits(3, rnd8(), tis_pkg::SHIFT_IR, tis_pkg::EXIT1_IR);
            stp(1'h0, rb(), tis_pkg::PAUSE_IR);
            stp(1'h0, rb(), tis_pkg::PAUSE_IR);
            stp(1'h1, rb(), tis_pkg::EXIT2_IR);
            stp(1'h0, rb(), tis_pkg::SHIFT_IR);
            shiftBits(3, {5'h00, v}, tis_pkg::SHIFT_IR, tis_pkg::EXIT1_IR);
            stp(1'h0, rb(), tis_pkg::PAUSE_IR);
            stp(1'h1, rb(), tis_pkg::EXIT2_IR);
            // leave the scan and latch the new instruction
            stp(1'h1, rb(), tis_pkg::UPDATE_IR);
            stp(1'h1, rb(), tis_pkg::SELECT_DR_SCAN);
            stp(1'h0, rb(), tis_pkg::CAPTURE_DR);
            stp(1'h0, rb(), tis_pkg::SHIFT_DR);
            shiftBits(8, rnd8(), tis_pkg::SHIFT_DR, tis_pkg::EXIT1_DR);
            stp(1'h1, rb(), tis_pkg::UPDATE_DR);
            stp(1'h0, rb(), tis_pkg::RUN_TEST_IDLE);
        end
        // clock enable low over a whole test clock pulse: the pulse is lost
        repeat (4) @(negedge clk_sys);
        ce = 1'h0;
        stp(1'h1, rb(), tis_pkg::RUN_TEST_IDLE);
        repeat (4) @(negedge clk_sys);
        ce = 1'h1;
        // edges are seen again once enabled
        stp(1'h1, rb(), tis_pkg::SELECT_DR_SCAN);
        repeat (20) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule

`default_nettype wire
